// file: bench/atg_afe_model.sv
// Analog front end model that answers touch conversions.
// Assumes requests change only just after rising clock edges.
`timescale 1ns/100ps
module atg_afe_model
    import atg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Sequencer side
    input wire atg_afe_req_t req,
    input wire logic [2:0] lat,
    output atg_afe_res_t res,
    output logic [15:0] last_q
);
    logic [2:0] cnt_q;
    logic [15:0] pat_q;
    // Count convert cycles; the pattern moves every cycle
    always_ff @(posedge sys_clk) begin
        pat_q <= rst ? 16'hA5C3 : pat_q + 16'h3B17;
        cnt_q <= (req.start && !rst) ? cnt_q + 3'h1 : 3'h0;
        if (res.done) begin
            last_q <= pat_q;
        end
    end
    // Done after lat cycles; data is junk outside done
    assign res.done = req.start && cnt_q == lat;
    assign res.data = res.done ? pat_q : ~pat_q;
endmodule

// file: bench/atg_touch_guard_assertions.sv
// Checker for the touch and guard block.
// Assumes one clock and the bus timing of the block's top ports.
`timescale 1ns/100ps
module atg_tg_chk
    import atg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Front end, guard and pins
    input wire atg_afe_req_t afe_req,
    input wire atg_afe_res_t afe_res,
    input wire logic conv_valid,
    input wire logic converter_low_power_select,
    input wire logic reset_request
);
    logic launch_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Launch write seen one cycle back
    always_ff @(posedge sys_clk) begin
        launch_q <= avs_write && avs_address == 8'h4C;
    end
    // Phase ends of a touch run
    sequence s_disch_end;
        afe_req.discharge ##1 !afe_req.discharge;
    endsequence
    sequence s_chg_end;
        afe_req.charge ##1 !afe_req.charge;
    endsequence
    a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read not answered");
    a_launch_cause: assert property ($rose(afe_req.discharge) |-> launch_q)
        else $error("discharge without launch write");
    a_disch_to_chg: assert property (s_disch_end |-> afe_req.charge)
        else $error("charge did not follow discharge");
    a_chg_to_conv: assert property (s_chg_end |-> afe_req.start)
        else $error("convert did not follow charge");
    a_start_entry: assert property ($rose(afe_req.start) |-> $past(afe_req.charge))
        else $error("convert without charge");
    a_start_hold: assert property (afe_req.start && !afe_res.done |=> afe_req.start)
        else $error("convert dropped early");
    a_phase_excl: assert property (
        $onehot0({afe_req.discharge, afe_req.charge, afe_req.start}))
        else $error("phases overlap");
    a_rr_single: assert property (reset_request |=> !reset_request)
        else $error("reset request too long");
    a_rr_cause: assert property (reset_request |-> $past(conv_valid))
        else $error("reset request without conversion");
    a_lp_reset: assert property ($past(rst) |-> converter_low_power_select)
        else $error("low power not set after reset");
endmodule
bind atg_touch_guard atg_tg_chk u_chk (.*);

// file: bench/tb_top.sv
// Self-checking bench: register traffic, touch runs and guard events.
// Assumes package, front end model and checker are compiled first.
`timescale 1ns/100ps
module tb_top
    import atg_pkg::*;
;
    logic sys_clk = 0;
    logic rst = 1;
    logic [7:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, v, q;
    logic [3:0] avs_byteenable;
    atg_afe_req_t afe_req;
    atg_afe_res_t afe_res;
    logic [15:0] first_injected_result, afe_last;
    logic conv_valid, conv_in_scan, reset_request;
    logic [11:0] conv_value;
    logic converter_clock_duty_select, converter_low_power_select, converter_power_on;
    logic [2:0] touch_current_trim, afe_lat;
    logic touch_multimask_enable;
    logic [7:0] touch_channel_drive_enables;
    logic [31:0] seed = 32'h5741;
    logic [4:0] ch_exp;
    int error_cnt = 0;
    int num_checks = 0;
    int nd, nc, nrr;
    wire [10:0] pins = {touch_channel_drive_enables, touch_multimask_enable,
        converter_clock_duty_select, converter_low_power_select};
    wire [3:0] ctl1 = {touch_current_trim, converter_power_on};
    atg_touch_guard u_dut (.*);
    atg_afe_model u_afe (.sys_clk, .rst, .req(afe_req), .lat(afe_lat), .res(afe_res),
        .last_q(afe_last));
    // Clock
    always #25 sys_clk = ~sys_clk;
    // Phase, pulse and channel monitor on settled values
    always @(negedge sys_clk) begin
        nd += afe_req.discharge;
        nc += afe_req.charge;
        nrr += reset_request;
        if (afe_req.start) begin
            chk("channel", ch_exp, afe_req.channel);
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Hold until the edge that sees waitrequest low; data is taken there
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        r = avs_readdata;
        if (avs_waitrequest !== 1'b0) chk("bus wait", 0, 1);
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1, ad, d, q);
    endtask
    task automatic rdc(input string n, input logic [7:0] ad, input logic [31:0] e);
        bus(0, ad, 32'h0000_0000, q);
        chk(n, e, q);
    endtask
    task automatic touch(input logic [4:0] ch, input logic [10:0] c, input logic [10:0] d);
        int n;
        ch_exp = ch;
        wr(8'h68, {12'h001, 15'h0000, ch});
        wr(8'h3C, {21'h00_0000, c});
        afe_lat <= seed[2:0];
        nd = 0;
        nc = 0;
        wr(8'h4C, {21'h00_0000, d});
        n = 0;
        do begin
            bus(0, 8'h64, 32'h0000_0000, q);
            n++;
        end while (q[1] !== 1'b1 && n < 3000);
        chk("end flag", 32'h0000_0002, q & 32'h0000_0002);
        chk("discharge cycles", d, nd);
        chk("charge cycles", c, nc);
        rdc("result", 8'h4C, {16'h0000, afe_last});
    endtask
    task automatic conv(input logic [11:0] x, input logic s);
        @(posedge sys_clk);
        conv_valid <= 1;
        conv_value <= x;
        conv_in_scan <= s;
        @(posedge sys_clk);
        conv_valid <= 0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        avs_address = 8'h00;
        avs_read = 0;
        avs_write = 0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        first_injected_result = 16'h0000;
        conv_valid = 0;
        conv_value = 12'h000;
        conv_in_scan = 0;
        afe_lat = 3'h0;
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        rdc("ctl3", 8'h50, 32'h0000_0001);
        rdc("win1", 8'h54, 32'h0FFF_0000);
        rdc("win2", 8'h58, 32'h0FFF_0000);
        rdc("result", 8'h4C, 32'h0000_0000);
        rdc("unmapped", 8'h00, 32'h0000_0000);
        $display("reset values done");
        repeat (16) begin
            v = rnd();
            wr(8'h50, v);
            wr(8'h60, v);
            rdc("ctl3", 8'h50, v & 32'h00FF_007F);
            chk("pins", {v[23:16], v[2:0]}, pins);
            chk("ctl1 pins", {v[6:4], v[0]}, ctl1);
            v = rnd();
            wr(8'h54, v);
            rdc("win1", 8'h54, v & 32'h0FFF_0FFF);
            wr(8'h58, v);
            rdc("win2", 8'h58, v & 32'h0FFF_0FFF);
            first_injected_result <= v[31:16];
            rdc("injected", 8'h3C, {16'h0000, v[31:16]});
        end
        avs_byteenable <= 4'h3;
        wr(8'h54, 32'h0ABC_0DEF);
        avs_byteenable <= 4'hF;
        rdc("win1 half", 8'h54, {4'h0, v[27:16], 4'h0, 12'hDEF});
        $display("registers done");
        wr(8'h60, 32'h0000_0003);
        touch(5'h00, 11'h001, 11'h001);
        touch(5'h07, 11'h003, 11'h7FF);
        repeat (4) begin
            v = rnd();
            touch({2'b00, v[2:0]}, v[13:3] & 11'h03F | 11'h001,
                v[24:14] & 11'h03F | 11'h001);
        end
        wr(8'h60, 32'h0000_0001);
        rdc("sequence", 8'h68, {12'h001, 15'h0000, ch_exp});
        nd = 0;
        wr(8'h4C, 32'h0000_0005);
        repeat (8) @(posedge sys_clk);
        chk("idle launch", 0, nd);
        $display("touch done");
        wr(8'h6C, 32'h0200_0100);
        wr(8'h54, 32'h0200_0100);
        wr(8'h58, 32'h0200_0100);
        wr(8'h50, 32'h0000_0021);
        nrr = 0;
        conv(12'h200, 0);
        conv(12'h100, 0);
        conv(12'h300, 1);
        rdc("in range", 8'h50, 32'h0000_0021);
        conv(12'h201, 0);
        conv(12'h0FF, 0);
        rdc("out of range", 8'h50, 32'h0000_0721);
        chk("reset pulses", 1, nrr);
        wr(8'h50, 32'h0000_0521);
        rdc("clear one", 8'h50, 32'h0000_0521);
        wr(8'h50, 32'h0000_0029);
        conv(12'h300, 1);
        rdc("scan", 8'h50, 32'h0000_0729);
        chk("reset pulses", 2, nrr);
        $display("guard done");
        report_and_stop();
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule

// file: src/atg_params.svh
// Register offsets, field positions and reset values for the touch and guard block.
// Assumes inclusion by the single design module.
`ifndef ATG_PARAMS_SVH
`define ATG_PARAMS_SVH
`define ATG_OFF_CHG 8'h3C
`define ATG_OFF_DISCHG 8'h4C
`define ATG_OFF_CTL3 8'h50
`define ATG_OFF_WIN1 8'h54
`define ATG_OFF_WIN2 8'h58
`define ATG_OFF_CTL1 8'h60
`define ATG_OFF_STAT 8'h64
`define ATG_OFF_SEQ3 8'h68
`define ATG_OFF_WIN0 8'h6C
`define ATG_BIT_RES2 10
`define ATG_BIT_RES1 9
`define ATG_BIT_RES0 8
`define ATG_BIT_RST2 6
`define ATG_BIT_RST1 5
`define ATG_BIT_RST0 4
`define ATG_BIT_SCAN 3
`define ATG_BIT_MMASK 2
`define ATG_BIT_DUTY 1
`define ATG_BIT_LP 0
`define ATG_CTL3_RESET 32'h0000_0001
`define ATG_WIN_RESET 32'h0FFF_0000
`define ATG_HI_MSB 27
`define ATG_HI_LSB 16
`define ATG_DRV_MSB 23
`define ATG_DRV_LSB 16
`define ATG_BIT_CONVERTER_POWER_ON 0
`define ATG_BIT_TKEN 1
`define ATG_TRIM_MSB 6
`define ATG_TRIM_LSB 4
`define ATG_BIT_EOC 1
`define ATG_SEQ_LEN_MSB 23
`define ATG_SEQ_LEN_LSB 20
`endif

// file: src/atg_pkg.sv
// Types shared by the touch and guard block.
// Assumes the params header sits beside it.
package atg_pkg;
    typedef enum logic [3:0] {
        ATG_IDLE = 4'b0001,
        ATG_DISCH = 4'b0010,
        ATG_CHARGE = 4'b0100,
        ATG_CONV = 4'b1000
    } atg_state_t;

    // Request to the analog front end
    typedef struct packed {
        logic discharge;
        logic charge;
        logic start;
        logic [4:0] channel;
    } atg_afe_req_t;

    // Result from the analog front end
    typedef struct packed {
        logic done;
        logic [15:0] data;
    } atg_afe_res_t;
endpackage

// file: src/atg_touch_guard.sv
// Touch sense sequencer, guard windows and extra converter control registers.
// Assumes one clock, an Avalon-MM master and an analog front end that answers done.
//
// Summary of operation
// - Each guard window flags a result above its high or below its low limit.
// - Guard flags set by hardware only; software write 0 clears, 1 keeps.
// - Per-window reset request enables at bits 6, 5, 4, reset zero.
// - Bit 3 enables guard checking across scanned channels, reset zero.
// - Bit 1 selects the delayed high phase or the normal duty clock.
// - Bit 0 selects low power, reset one; zero means high power.
// - Window one register at 0x54: high 27:16 resets 0xFFF, low 11:0 zero.
// - Window two register at 0x58 has the same layout and reset values.
// - A separate trim field adjusts the touch charging current.
// - Touch works single channel, measuring the first regular sequence slot.
// - Discharge for programmed cycles, then charge for programmed cycles, then convert.
// - One shared discharge count and one charge count for all channels.
// - Writing the 11-bit discharge field loads it, and launches a measurement when idle with touch enable and converter power on.
// - Charge time field is write only, 11 bits, in clock cycles, reset zero.
// - At 0x3C writes load charge time; reads return first injected result.
// - At 0x4C writes launch discharge when touch enable and converter power are on; reads return 16-bit regular result.
// - Clearing touch enable leaves the converter channel settings intact.
// - Bits 23:16 hold per-channel multi-mask drive enables, reset zero.
// - Threshold changes apply only from the next conversion.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "atg_params.svh"

module atg_touch_guard
    import atg_pkg::*;
#(
    parameter int CNT_W = 11,
    parameter int DRV_W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog front end
    output atg_afe_req_t afe_req,
    input wire atg_afe_res_t afe_res,
    input wire logic [15:0] first_injected_result,
    // Conversion stream from the core converter for guard checking
    input wire logic conv_valid,
    input wire logic [11:0] conv_value,
    input wire logic conv_in_scan,
    // Converter settings toward the analog side
    output logic converter_clock_duty_select,
    output logic converter_low_power_select,
    output logic converter_power_on,
    output logic [2:0] touch_current_trim,
    output logic touch_multimask_enable,
    output logic [DRV_W-1:0] touch_channel_drive_enables,
    // Reset request toward the reset controller
    output logic reset_request
);
    // Control and configuration
    logic [2:0] out_of_range_q;
    logic [2:0] rst_en_q;
    logic scan_en_q, mmask_q, duty_q, lp_q;
    logic [DRV_W-1:0] drv_q;
    logic [11:0] hi1_q, lo1_q, hi2_q, lo2_q, hi0_q, lo0_q;
    logic [11:0] hi_lat [3];
    logic [11:0] lo_lat [3];
    logic converter_power_on_q, tken_q;
    logic [2:0] trim_q;
    logic [4:0] slot1_q;
    logic [3:0] seq_len_q;
    logic [CNT_W-1:0] chg_q, dis_q, cnt_q;
    logic [15:0] result_q;
    logic eoc_q;
    atg_state_t state_q;
    logic [31:0] rdata_q;
    logic rack_q;
    logic wr_ctl3, wr_dis;
    logic [2:0] hit;

    // Reset images of the control and window registers
    localparam logic [31:0] CTL3_RST = `ATG_CTL3_RESET;
    localparam logic [31:0] WIN_RST = `ATG_WIN_RESET;

    assign wr_ctl3 = avs_write && avs_address == `ATG_OFF_CTL3;
    assign wr_dis = avs_write && avs_address == `ATG_OFF_DISCHG;

    // Writes complete at once; reads take one wait cycle
    assign avs_waitrequest = avs_read && !rack_q;
    assign avs_readdata = rdata_q;

    // Read data capture
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rack_q <= avs_read && !rack_q;
            if (avs_read && !rack_q) begin
                unique case (avs_address)
                    `ATG_OFF_CHG: rdata_q <= {16'h0000, first_injected_result};
                    `ATG_OFF_DISCHG: rdata_q <= {16'h0000, result_q};
                    `ATG_OFF_CTL3: rdata_q <= {8'h00, drv_q, 5'h00, out_of_range_q, 1'b0,
                        rst_en_q, scan_en_q, mmask_q, duty_q, lp_q};
                    `ATG_OFF_WIN1: rdata_q <= {4'h0, hi1_q, 4'h0, lo1_q};
                    `ATG_OFF_WIN2: rdata_q <= {4'h0, hi2_q, 4'h0, lo2_q};
                    `ATG_OFF_WIN0: rdata_q <= {4'h0, hi0_q, 4'h0, lo0_q};
                    `ATG_OFF_CTL1: rdata_q <= {25'h000_0000, trim_q, 2'b00, tken_q, converter_power_on_q};
                    `ATG_OFF_STAT: rdata_q <= {30'h0000_0000, eoc_q, 1'b0};
                    `ATG_OFF_SEQ3: rdata_q <= {8'h00, seq_len_q, 15'h0000, slot1_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Reset request enables, one per window
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rst_en_q <= CTL3_RST[`ATG_BIT_RST2:`ATG_BIT_RST0];
        end else if (wr_ctl3 && avs_byteenable[0]) begin
            rst_en_q <= avs_writedata[`ATG_BIT_RST2:`ATG_BIT_RST0];
        end
    end

    // Guard scan enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scan_en_q <= CTL3_RST[`ATG_BIT_SCAN];
        end else if (wr_ctl3 && avs_byteenable[0]) begin
            scan_en_q <= avs_writedata[`ATG_BIT_SCAN];
        end
    end

    // Touch multi-mask enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mmask_q <= CTL3_RST[`ATG_BIT_MMASK];
        end else if (wr_ctl3 && avs_byteenable[0]) begin
            mmask_q <= avs_writedata[`ATG_BIT_MMASK];
        end
    end

    // Converter clock duty select
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            duty_q <= CTL3_RST[`ATG_BIT_DUTY];
        end else if (wr_ctl3 && avs_byteenable[0]) begin
            duty_q <= avs_writedata[`ATG_BIT_DUTY];
        end
    end

    // Converter low power select, set out of reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lp_q <= CTL3_RST[`ATG_BIT_LP];
        end else if (wr_ctl3 && avs_byteenable[0]) begin
            lp_q <= avs_writedata[`ATG_BIT_LP];
        end
    end

    // Per-channel touch drive enables in the third byte lane
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drv_q <= '0;
        end else if (wr_ctl3 && avs_byteenable[2]) begin
            drv_q <= avs_writedata[`ATG_DRV_MSB:`ATG_DRV_LSB];
        end
    end

    // Window one limits; a half needs both of its byte lanes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hi1_q <= WIN_RST[`ATG_HI_MSB:`ATG_HI_LSB];
            lo1_q <= WIN_RST[11:0];
        end else if (avs_write && avs_address == `ATG_OFF_WIN1) begin
            if (&avs_byteenable[3:2]) hi1_q <= avs_writedata[`ATG_HI_MSB:`ATG_HI_LSB];
            if (&avs_byteenable[1:0]) lo1_q <= avs_writedata[11:0];
        end
    end

    // Window two limits, same layout as window one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hi2_q <= WIN_RST[`ATG_HI_MSB:`ATG_HI_LSB];
            lo2_q <= WIN_RST[11:0];
        end else if (avs_write && avs_address == `ATG_OFF_WIN2) begin
            if (&avs_byteenable[3:2]) hi2_q <= avs_writedata[`ATG_HI_MSB:`ATG_HI_LSB];
            if (&avs_byteenable[1:0]) lo2_q <= avs_writedata[11:0];
        end
    end

    // Window zero limits, same layout again
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hi0_q <= WIN_RST[`ATG_HI_MSB:`ATG_HI_LSB];
            lo0_q <= WIN_RST[11:0];
        end else if (avs_write && avs_address == `ATG_OFF_WIN0) begin
            if (&avs_byteenable[3:2]) hi0_q <= avs_writedata[`ATG_HI_MSB:`ATG_HI_LSB];
            if (&avs_byteenable[1:0]) lo0_q <= avs_writedata[11:0];
        end
    end

    // Converter control: power, touch enable, current trim
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            converter_power_on_q <= 1'b0;
            tken_q <= 1'b0;
            trim_q <= 3'b000;
        end else if (avs_write && avs_byteenable[0] && avs_address == `ATG_OFF_CTL1) begin
            converter_power_on_q <= avs_writedata[`ATG_BIT_CONVERTER_POWER_ON];
            tken_q <= avs_writedata[`ATG_BIT_TKEN];
            trim_q <= avs_writedata[`ATG_TRIM_MSB:`ATG_TRIM_LSB];
        end
    end

    // Sequence slot; touch enable leaves it untouched
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slot1_q <= 5'h00;
            seq_len_q <= 4'h0;
        end else if (avs_write && avs_byteenable[0] && avs_address == `ATG_OFF_SEQ3) begin
            slot1_q <= avs_writedata[4:0];
            seq_len_q <= avs_writedata[`ATG_SEQ_LEN_MSB:`ATG_SEQ_LEN_LSB];
        end
    end

    // Shared charge count, write only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chg_q <= '0;
        end else if (avs_write && avs_address == `ATG_OFF_CHG) begin
            chg_q <= avs_writedata[CNT_W-1:0];
        end
    end

    // Shared discharge count, loaded by the launching write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dis_q <= '0;
        end else if (wr_dis) begin
            dis_q <= avs_writedata[CNT_W-1:0];
        end
    end

    // Touch sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ATG_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                ATG_IDLE: begin
                    if (wr_dis && tken_q && converter_power_on_q) begin
                        state_q <= ATG_DISCH;
                        cnt_q <= avs_writedata[CNT_W-1:0];
                    end
                end
                ATG_DISCH: begin
                    if (cnt_q <= CNT_W'(1)) begin
                        state_q <= ATG_CHARGE;
                        cnt_q <= chg_q;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                ATG_CHARGE: begin
                    if (cnt_q <= CNT_W'(1)) begin
                        state_q <= ATG_CONV;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                ATG_CONV: begin
                    if (afe_res.done) state_q <= ATG_IDLE;
                end
            endcase
        end
    end

    // Front end requests
    always_comb begin
        afe_req.discharge = state_q == ATG_DISCH;
        afe_req.charge = state_q == ATG_CHARGE;
        afe_req.start = state_q == ATG_CONV;
        afe_req.channel = slot1_q;
    end

    // Result register, loaded as the front end finishes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= 16'h0000;
        end else if (state_q == ATG_CONV && afe_res.done) begin
            result_q <= afe_res.data;
        end
    end

    // End of conversion; a new result beats a launch or result read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            eoc_q <= 1'b0;
        end else if (state_q == ATG_CONV && afe_res.done) begin
            eoc_q <= 1'b1;
        end else if (wr_dis || (avs_read && rack_q && avs_address == `ATG_OFF_DISCHG)) begin
            eoc_q <= 1'b0;
        end
    end

    // Latch limits on every cycle without conv_valid so edits apply next time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                hi_lat[i] <= WIN_RST[`ATG_HI_MSB:`ATG_HI_LSB];
                lo_lat[i] <= WIN_RST[11:0];
            end
        end else if (!conv_valid) begin
            hi_lat[0] <= hi0_q;
            lo_lat[0] <= lo0_q;
            hi_lat[1] <= hi1_q;
            lo_lat[1] <= lo1_q;
            hi_lat[2] <= hi2_q;
            lo_lat[2] <= lo2_q;
        end
    end

    // Window comparisons
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            hit[i] = conv_valid && (scan_en_q || !conv_in_scan) &&
                (conv_value > hi_lat[i] || conv_value < lo_lat[i]);
        end
    end

    // Sticky flags: set wins, write 0 clears, write 1 keeps
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_of_range_q <= 3'b000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (hit[i]) begin
                    out_of_range_q[i] <= 1'b1;
                end else if (wr_ctl3 && avs_byteenable[1] &&
                    !avs_writedata[`ATG_BIT_RES0 + i]) begin
                    out_of_range_q[i] <= 1'b0;
                end
            end
        end
    end

    // One pulse when any enabled flag newly sets, however many set together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reset_request <= 1'b0;
        end else begin
            reset_request <= |(hit & ~out_of_range_q & rst_en_q);
        end
    end

    // Settings toward the analog side
    assign converter_clock_duty_select = duty_q;
    assign converter_low_power_select = lp_q;
    assign converter_power_on = converter_power_on_q;
    assign touch_current_trim = trim_q;
    assign touch_multimask_enable = mmask_q;
    assign touch_channel_drive_enables = drv_q;
endmodule
